// *** design/hfp_crc.sv ***
// Bit-serial CRC-16 / CRC-32 engine, reflected, LSB first.
// Assumes the caller pulses init before each frame and holds wide steady.
`timescale 1ns/1ps
`default_nettype none

module hfp_crc
  import hfp_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Control and data.
  input  wire logic        init_in,
  input  wire logic        en_in,
  input  wire logic        bit_in,
  input  wire logic        wide_in,
  // Remainder now and after this bit.
  output logic      [31:0] crc_out,
  output logic      [31:0] crc_next_out
);

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b, input logic w);
    logic [31:0] s;
    s = {1'b0, c[31:1]} ^ ((c[0] ^ b) ? (w ? CRC32_POLY : CRC16_POLY) : 32'h0000_0000);
    return w ? s : (s & CRC16_INIT);
  endfunction : crc_step

  assign crc_next_out = crc_step(crc_out, bit_in, wide_in);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      crc_out <= CRC32_INIT;
    end else if (init_in) begin
      crc_out <= wide_in ? CRC32_INIT : CRC16_INIT;
    end else if (en_in) begin
      crc_out <= crc_next_out;
    end
  end

endmodule : hfp_crc

`default_nettype wire

// *** design/hfp_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides, flip-flop storage.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
`default_nettype none

module hfp_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Filling side.
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Draining side.
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              full;
  wire              empty;
  wire              do_wr;
  wire              do_rd;

  assign full          = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty         = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready_out  = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign do_wr         = in_valid_in & ~full;
  assign do_rd         = out_ready_in & ~empty;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // Storage needs no reset; only slots behind the write pointer are read.
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end

endmodule : hfp_fifo

`default_nettype wire

// *** design/hfp_pkg.sv ***
// Shared constants and types of the HDLC frame terminal port.
// Assumes a 40 MHz system clock; every cycle count below derives from it.
package hfp_pkg;

  // ----------------------------------------------------------------
  // Clock rates and derived cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned TX_CLK_HALF_NS  = 100;
  localparam int unsigned TX_CLK_HALF_CYC = (TX_CLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RX_CLK_HIGH_NS  = 75;
  localparam int unsigned RX_CLK_HIGH_CYC = (RX_CLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  TX_HALF_LAST    = 3'(TX_CLK_HALF_CYC - 1);
  localparam logic [2:0]  RX_HIGH_LAST    = 3'(RX_CLK_HIGH_CYC - 1);

  // ----------------------------------------------------------------
  // Octets, runs and trailer lengths
  // ----------------------------------------------------------------
  localparam logic [7:0]  FLAG_OCTET  = 8'h7e;
  localparam logic [7:0]  ABORT_BYTE  = 8'hff;
  localparam logic [2:0]  STUFF_RUN   = 3'h5;
  localparam logic [2:0]  FLAG_RUN    = 3'h6;
  localparam logic [2:0]  RUN_MAX     = 3'h7;
  localparam logic [5:0]  BYTE_BITS   = 6'h08;
  localparam logic [5:0]  FCS16_BITS  = 6'h10;
  localparam logic [5:0]  FCS32_BITS  = 6'h20;
  localparam logic [3:0]  FCS16_BYTES = 4'h2;
  localparam logic [3:0]  FCS32_BYTES = 4'h4;
  localparam logic [3:0]  NBYTES_MAX  = 4'hf;

  // ----------------------------------------------------------------
  // Frame check sequence (reflected, LSB first)
  // ----------------------------------------------------------------
  localparam logic [31:0] CRC16_POLY = 32'h0000_8408;
  localparam logic [31:0] CRC32_POLY = 32'hedb8_8320;
  localparam logic [31:0] CRC16_INIT = 32'h0000_ffff;
  localparam logic [31:0] CRC32_INIT = 32'hffff_ffff;
  localparam logic [31:0] CRC16_GOOD = 32'h0000_f0b8;
  localparam logic [31:0] CRC32_GOOD = 32'hdebb_20e3;

  // ----------------------------------------------------------------
  // Buffer and serializer
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned TOKEN_W    = 9;

  typedef enum logic [1:0] {TXM_FLAG, TXM_DATA, TXM_FCS} hfp_txmode_t;

endpackage : hfp_pkg

// *** design/hfp_port.sv ***
// HDLC frame terminal port: byte interface to the terminal, serial
// payload bits toward the line framer, in both directions.
// Assumes the line framer gives one payload slot per rising edge of
// line_clk_in, and the terminal times its tx inputs on our demand clock.
`timescale 1ns/1ps
`default_nettype none

module hfp_port
  import hfp_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  // Configuration.
  input  wire logic       crc32_sel_in,
  // Terminal transmit side.
  input  wire logic       send_message_in,
  input  wire logic       send_check_seq_in,
  input  wire logic [7:0] tx_frame_byte_in,
  output logic            tx_frame_clock_out,
  // Terminal receive side.
  output logic            rx_frame_clock_out,
  output logic      [7:0] rx_frame_byte_out,
  output logic            rx_flag_indicator_out,
  output logic            rx_check_ok_indicator_out,
  // Line framer payload side.
  input  wire logic       line_clk_in,
  input  wire logic       line_rx_bit_in,
  output logic            line_tx_bit_out
);

  // ----------------------------------------------------------------
  // Line clock and data synchronisers
  // ----------------------------------------------------------------
  logic [2:0] lclk_sync_reg;
  logic [2:0] lbit_sync_reg;
  logic       lclk_lvl_reg;
  wire        line_edge;
  wire        rx_b;

  // A rising edge counts once the second and third stages agree high.
  assign line_edge = lclk_sync_reg[1] & lclk_sync_reg[2] & ~lclk_lvl_reg;
  assign rx_b      = lbit_sync_reg[2];

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lclk_sync_reg <= 3'h0;
      lbit_sync_reg <= 3'h0;
      lclk_lvl_reg  <= 1'b0;
    end else begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], line_clk_in};
      lbit_sync_reg <= {lbit_sync_reg[1:0], line_rx_bit_in};
      if (lclk_sync_reg[1] == lclk_sync_reg[2]) begin
        lclk_lvl_reg <= lclk_sync_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit demand clock and byte capture
  // ----------------------------------------------------------------
  logic       tx_clk_reg;
  logic [2:0] tx_cnt_reg;
  logic       fcs_seen_reg;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [8:0]  fifo_out_data;
  wire        fifo_pop;
  wire        tx_rise;
  wire        push_mark;
  wire        push_data;
  wire        fifo_push;

  // Demand clock stalls while the buffer is full.
  assign tx_rise   = ~tx_clk_reg & (tx_cnt_reg == 3'h0) & fifo_in_ready;
  // Only the first period of send-check makes a trailer request.
  assign push_mark = send_check_seq_in & ~fcs_seen_reg;
  // Bytes are taken only while send-message is high.
  assign push_data = send_message_in & ~send_check_seq_in;
  // Capture on the rising demand clock edge.
  assign fifo_push = tx_rise & (push_mark | push_data);

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_clk_reg   <= 1'b0;
      tx_cnt_reg   <= 3'h0;
      fcs_seen_reg <= 1'b0;
    end else if (tx_rise) begin
      tx_clk_reg   <= 1'b1;
      tx_cnt_reg   <= TX_HALF_LAST;
      fcs_seen_reg <= send_check_seq_in;
    end else if (tx_cnt_reg != 3'h0) begin
      tx_cnt_reg <= tx_cnt_reg - 3'h1;
    end else if (tx_clk_reg) begin
      tx_clk_reg <= 1'b0;
      tx_cnt_reg <= TX_HALF_LAST;
    end
  end

  hfp_fifo #(
    .WIDTH (TOKEN_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (mclk_in),
    .rst_in        (sys_rst_in),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({push_mark, tx_frame_byte_in}),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Transmit serializer
  // ----------------------------------------------------------------
  hfp_txmode_t tx_mode_reg;
  hfp_txmode_t ld_mode;
  logic [31:0] tx_sh_reg;
  logic [31:0] ld_sh;
  logic [5:0]  tx_left_reg;
  logic [5:0]  ld_left;
  logic [2:0]  tx_ones_reg;
  logic        line_tx_bit_reg;
  logic        ld_pop;
  logic        ld_init;
  wire  [31:0] tx_crc_next;
  wire  [31:0] fcs_word;
  wire  [5:0]  fcs_bits;
  wire         stuff_now;
  wire         tx_shift;
  wire         tx_last;

  // Five ones in a row force a zero into the next slot.
  assign stuff_now = (tx_ones_reg == STUFF_RUN);
  assign tx_shift  = line_edge & ~stuff_now;
  assign tx_last   = tx_shift & (tx_left_reg == 6'h01);
  assign fifo_pop  = tx_last & ld_pop;
  // Trailer length and mask follow the CRC width select.
  assign fcs_bits  = crc32_sel_in ? FCS32_BITS : FCS16_BITS;
  assign fcs_word  = ~tx_crc_next & (crc32_sel_in ? CRC32_INIT : CRC16_INIT);

  always_comb begin
    ld_mode = TXM_FLAG;
    ld_sh   = {24'h00_0000, FLAG_OCTET};
    ld_left = BYTE_BITS;
    ld_pop  = 1'b0;
    ld_init = 1'b0;
    case (tx_mode_reg)
      TXM_FLAG: begin
        // A stray trailer request outside a frame is dropped.
        if (fifo_out_valid) begin
          ld_pop = 1'b1;
          if (!fifo_out_data[8]) begin
            ld_mode = TXM_DATA;
            ld_sh   = {24'h00_0000, fifo_out_data[7:0]};
            ld_init = 1'b1;
          end
        end
      end
      TXM_DATA: begin
        // An empty buffer mid-frame closes it with a flag and no trailer.
        if (fifo_out_valid) begin
          ld_pop = 1'b1;
          if (fifo_out_data[8]) begin
            ld_mode = TXM_FCS;
            ld_sh   = fcs_word;
            ld_left = fcs_bits;
          end else begin
            ld_mode = TXM_DATA;
            ld_sh   = {24'h00_0000, fifo_out_data[7:0]};
          end
        end
      end
      default: begin
        ld_mode = TXM_FLAG;
      end
    endcase
  end

  hfp_crc u_tx_crc (
    .clk_in       (mclk_in),
    .rst_in       (sys_rst_in),
    .init_in      (tx_last & ld_init),
    .en_in        (tx_shift & (tx_mode_reg == TXM_DATA)),
    .bit_in       (tx_sh_reg[0]),
    .wide_in      (crc32_sel_in),
    .crc_out      (),
    .crc_next_out (tx_crc_next)
  );

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_mode_reg     <= TXM_FLAG;
      tx_sh_reg       <= {24'h00_0000, FLAG_OCTET};
      tx_left_reg     <= BYTE_BITS;
      tx_ones_reg     <= 3'h0;
      line_tx_bit_reg <= 1'b0;
    end else if (line_edge && stuff_now) begin
      line_tx_bit_reg <= 1'b0;
      tx_ones_reg     <= 3'h0;
    end else if (tx_shift) begin
      // One payload bit per line slot.
      line_tx_bit_reg <= tx_sh_reg[0];
      if (tx_mode_reg == TXM_FLAG || !tx_sh_reg[0]) begin
        tx_ones_reg <= 3'h0;
      end else begin
        tx_ones_reg <= tx_ones_reg + 3'h1;
      end
      if (tx_last) begin
        // Idle fill reloads the flag octet.
        tx_mode_reg <= ld_mode;
        tx_sh_reg   <= ld_sh;
        tx_left_reg <= ld_left;
      end else begin
        tx_sh_reg   <= {1'b0, tx_sh_reg[31:1]};
        tx_left_reg <= tx_left_reg - 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive deframer
  // ----------------------------------------------------------------
  logic [2:0] rx_ones_reg;
  logic [6:0] rx_dline_reg;
  logic [2:0] rx_dcnt_reg;
  logic [7:0] rx_sh_reg;
  logic [2:0] rx_bits_reg;
  logic [3:0] rx_nbytes_reg;
  logic       rx_inframe_reg;
  wire [31:0] rx_crc;
  wire [3:0]  rx_fcs_bytes;
  wire [7:0]  rx_byte_next;
  wire        rx_flag;
  wire        rx_abort;
  wire        rx_plain;
  wire        rx_commit;
  wire        rx_byte_done;
  wire        rx_end;
  wire        rx_good;

  assign rx_flag  = line_edge & ~rx_b & (rx_ones_reg == FLAG_RUN);
  assign rx_abort = line_edge & rx_b & (rx_ones_reg == FLAG_RUN) & rx_inframe_reg;
  // A zero after five ones is dropped as a stuffed bit.
  assign rx_plain = line_edge & ~(rx_b ? (rx_ones_reg >= FLAG_RUN)
                                       : (rx_ones_reg == STUFF_RUN || rx_ones_reg == FLAG_RUN));
  // Bits are held back seven places so a closing flag never reaches the check.
  assign rx_commit    = rx_plain & rx_inframe_reg & (rx_dcnt_reg == RUN_MAX);
  assign rx_byte_next = {rx_dline_reg[0], rx_sh_reg[7:1]};
  assign rx_byte_done = rx_commit & (rx_bits_reg == 3'h7);
  assign rx_fcs_bytes = crc32_sel_in ? FCS32_BYTES : FCS16_BYTES;
  assign rx_end       = rx_flag & rx_inframe_reg & (rx_bits_reg == 3'h0) & (rx_nbytes_reg > rx_fcs_bytes);
  assign rx_good      = crc32_sel_in ? (rx_crc == CRC32_GOOD) : (rx_crc[15:0] == CRC16_GOOD[15:0]);

  hfp_crc u_rx_crc (
    .clk_in       (mclk_in),
    .rst_in       (sys_rst_in),
    .init_in      (rx_flag),
    .en_in        (rx_commit),
    .bit_in       (rx_dline_reg[0]),
    .wide_in      (crc32_sel_in),
    .crc_out      (rx_crc),
    .crc_next_out ()
  );

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_ones_reg    <= 3'h0;
      rx_dline_reg   <= 7'h00;
      rx_dcnt_reg    <= 3'h0;
      rx_sh_reg      <= 8'h00;
      rx_bits_reg    <= 3'h0;
      rx_nbytes_reg  <= 4'h0;
      rx_inframe_reg <= 1'b0;
    end else if (line_edge) begin
      rx_ones_reg <= !rx_b ? 3'h0 : (rx_ones_reg == RUN_MAX) ? RUN_MAX : rx_ones_reg + 3'h1;
      if (rx_flag) begin
        rx_inframe_reg <= 1'b1;
        rx_dcnt_reg    <= 3'h0;
        rx_bits_reg    <= 3'h0;
        rx_nbytes_reg  <= 4'h0;
      end else if (rx_abort) begin
        rx_inframe_reg <= 1'b0;
      end else if (rx_plain && rx_inframe_reg) begin
        rx_dline_reg <= {rx_b, rx_dline_reg[6:1]};
        if (rx_dcnt_reg != RUN_MAX) begin
          rx_dcnt_reg <= rx_dcnt_reg + 3'h1;
        end
        if (rx_commit) begin
          rx_sh_reg   <= rx_byte_next;
          rx_bits_reg <= rx_bits_reg + 3'h1;
        end
        if (rx_byte_done && rx_nbytes_reg != NBYTES_MAX) begin
          rx_nbytes_reg <= rx_nbytes_reg + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive terminal outputs
  // ----------------------------------------------------------------
  logic       rx_clk_reg;
  logic [2:0] rx_cnt_reg;
  logic [7:0] rx_byte_reg;
  logic       rx_idle_reg;
  logic       rx_ok_reg;
  wire        rx_ev;

  assign rx_ev = rx_byte_done | rx_flag | rx_abort;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_clk_reg  <= 1'b0;
      rx_cnt_reg  <= 3'h0;
      rx_byte_reg <= 8'h00;
      rx_idle_reg <= 1'b0;
      rx_ok_reg   <= 1'b0;
    end else if (rx_ev) begin
      // Data and indicators change with the rising receive clock.
      rx_clk_reg  <= 1'b1;
      rx_cnt_reg  <= RX_HIGH_LAST;
      rx_byte_reg <= rx_byte_done ? rx_byte_next : rx_flag ? FLAG_OCTET : ABORT_BYTE;
      // Flag output raises the idle indicator.
      rx_idle_reg <= rx_flag;
      // Check-ok encodes frame result or abort.
      rx_ok_reg   <= rx_flag ? (rx_end & rx_good) : rx_abort;
    end else if (rx_cnt_reg != 3'h0) begin
      rx_cnt_reg <= rx_cnt_reg - 3'h1;
    end else begin
      rx_clk_reg <= 1'b0;
    end
  end

  assign tx_frame_clock_out        = tx_clk_reg;
  assign line_tx_bit_out           = line_tx_bit_reg;
  assign rx_frame_clock_out        = rx_clk_reg;
  assign rx_frame_byte_out         = rx_byte_reg;
  assign rx_flag_indicator_out     = rx_idle_reg;
  assign rx_check_ok_indicator_out = rx_ok_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_trailer_len_sel: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (tx_last && tx_mode_reg == TXM_DATA && fifo_out_valid && fifo_out_data[8])
    |=> tx_mode_reg == TXM_FCS && tx_left_reg == (crc32_sel_in ? FCS32_BITS : FCS16_BITS))
    else $error("trailer length does not follow the CRC width select");

  chk_idle_flag_fill: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (tx_last && !fifo_out_valid) |=> tx_mode_reg == TXM_FLAG && tx_sh_reg[7:0] == FLAG_OCTET)
    else $error("empty buffer did not reload a flag octet");

  chk_line_bit_slot: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !line_edge |=> $stable(line_tx_bit_reg))
    else $error("line bit changed outside a payload slot");

  chk_rx_flag_pulse: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rx_ev |=> $rose(rx_clk_reg) && (rx_idle_reg == $past(rx_flag)) && (!rx_idle_reg || rx_byte_reg == FLAG_OCTET))
    else $error("idle indicator disagrees with flag on byte bus");

  chk_good_frame_end: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (rx_end && rx_good) |=> rx_idle_reg && rx_ok_reg && rx_clk_reg)
    else $error("good frame not reported with both indicators high");

  chk_bad_frame_end: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (rx_end && !rx_good) |=> rx_idle_reg && !rx_ok_reg)
    else $error("bad frame not reported as idle high, check low");

  chk_abort_report: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rx_abort |=> !rx_idle_reg && rx_ok_reg && rx_byte_reg == ABORT_BYTE)
    else $error("abort not reported as idle low, check high");

  chk_rx_byte_edge: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $changed(rx_byte_reg) |-> $rose(rx_clk_reg))
    else $error("receive byte changed away from a rising clock");

  chk_tx_capture_edge: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    fifo_push |-> !tx_clk_reg ##1 tx_clk_reg)
    else $error("byte captured away from a rising demand clock");

  chk_no_send_no_push: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!send_message_in && !send_check_seq_in) |-> !fifo_push)
    else $error("byte taken while send-message low");

  chk_demand_clock_high: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $rose(tx_clk_reg) |-> tx_clk_reg [*4] ##1 !tx_clk_reg)
    else $error("demand clock high phase is not four cycles");

  chk_stuff_zero_bit: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (line_edge && tx_ones_reg == STUFF_RUN) |=> !line_tx_bit_reg && tx_ones_reg == 3'h0)
    else $error("no zero inserted after five ones");

endmodule : hfp_port

`default_nettype wire

// *** dv/hfp_term.sv ***
// Terminal equipment model: feeds transmit bytes, collects receive events.
// Assumes the port's demand and receive clocks are slow against mclk.
`timescale 1ns/1ps
`default_nettype none

module hfp_term (
  // Clock.
  input  wire logic       mclk_in,
  // Transmit side.
  input  wire logic       tx_clk_in,
  output logic            send_out,
  output logic            check_out,
  output logic      [7:0] byte_out,
  // Receive side.
  input  wire logic       rx_clk_in,
  input  wire logic [7:0] rx_byte_in,
  input  wire logic       idle_in,
  input  wire logic       ok_in
);
  logic [8:0] txq[$];
  logic [9:0] rxq[$];
  logic       tx_d = 1'b0;
  logic       rx_d = 1'b0;
  initial begin
    send_out = 1'b0;
    check_out = 1'b0;
    byte_out = 8'h00;
  end
  always @(posedge mclk_in) begin
    tx_d <= tx_clk_in;
    rx_d <= rx_clk_in;
    if (tx_d && !tx_clk_in) begin
      if (txq.size() > 0) begin
        {check_out, byte_out} <= txq[0];
        send_out <= !txq[0][8];
        void'(txq.pop_front());
      end else begin
        // Idle bus keeps changing so a stale byte is never taken for data.
        send_out <= 1'b0;
        check_out <= 1'b0;
        byte_out <= ~byte_out;
      end
    end
    if (rx_d && !rx_clk_in) rxq.push_back({idle_in, ok_in, rx_byte_in});
  end
endmodule : hfp_term
`default_nettype wire

// *** dv/test_hdlc_frame_terminal_port.sv ***
// Self-checking bench: payload line looped back, terminal model on both sides.
// Assumes the port and package in design/.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end

module test_hdlc_frame_terminal_port;
  import hfp_pkg::*;
  logic       mclk_in = 0, sys_rst_in = 1, crc32_sel_in = 0, line_clk_in = 0, ones = 0;
  logic       snd, chk, txc, rxc, idle, ok, ltx;
  logic [7:0] txb, rxb;
  int         bad_count = 0, checks = 0, cyc = 0;

  initial forever #12.5 mclk_in = ~mclk_in;
  initial begin
    #37;
    forever #100 line_clk_in = ~line_clk_in;
  end

  hfp_port dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .crc32_sel_in(crc32_sel_in),
    .send_message_in(snd), .send_check_seq_in(chk), .tx_frame_byte_in(txb), .tx_frame_clock_out(txc),
    .rx_frame_clock_out(rxc), .rx_frame_byte_out(rxb), .rx_flag_indicator_out(idle),
    .rx_check_ok_indicator_out(ok), .line_clk_in(line_clk_in), .line_rx_bit_in(ltx | ones),
    .line_tx_bit_out(ltx));
  hfp_term term (.mclk_in(mclk_in), .tx_clk_in(txc), .send_out(snd), .check_out(chk), .byte_out(txb),
    .rx_clk_in(rxc), .rx_byte_in(rxb), .idle_in(idle), .ok_in(ok));

  task automatic stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic idle_test;
    logic [9:0] e;
    repeat (1500) @(posedge mclk_in);
    repeat (3) begin
      e = term.rxq.pop_back();
      `CHK("idle flag", {2'b10, FLAG_OCTET}, e)
    end
  endtask : idle_test

  // Bytes ff and 7e force stuffing and look like abort and flag.
  task automatic frame(input int n, input logic wide, input logic trail);
    logic [7:0] exp[$];
    logic [9:0] e;
    int         got, k;
    crc32_sel_in <= wide;
    repeat (4) @(posedge mclk_in);
    term.rxq.delete();
    for (k = 0; k < n; k++) begin
      exp.push_back(8'hff - 8'(k * 129));
      term.txq.push_back({1'b0, exp[k]});
    end
    if (trail) repeat (wide ? 4 : 2) term.txq.push_back(9'h100);
    got = 0;
    for (k = 0; k < 20000; k++) begin
      @(posedge mclk_in);
      if (term.rxq.size() > 0) begin
        e = term.rxq.pop_front();
        if (e[9:8] == 2'b00) begin
          if (got < n) `CHK("rx byte", exp[got], e[7:0])
          got++;
        end else if (e[9] && got > 0) break;
      end
    end
    `CHK("byte count", n + (trail ? (wide ? 4 : 2) : 0), got)
    `CHK("end flag", {1'b1, trail, FLAG_OCTET}, e)
  endtask : frame

  task automatic abort_test;
    logic [9:0] e;
    int         k;
    e = 10'h200;
    term.rxq.delete();
    for (k = 0; k < 12; k++) term.txq.push_back({1'b0, 8'h55});
    // Ones are forced only after a data byte is out, so the abort lands mid-frame.
    for (k = 0; k < 5000 && e[9:8] != 2'b00; k++) begin
      @(posedge mclk_in);
      if (term.rxq.size() > 0) e = term.rxq.pop_front();
    end
    ones <= 1'b1;
    repeat (120) @(posedge mclk_in);
    ones <= 1'b0;
    for (k = 0; k < 3000 && e != {2'b01, ABORT_BYTE}; k++) begin
      @(posedge mclk_in);
      if (term.rxq.size() > 0) e = term.rxq.pop_front();
    end
    `CHK("abort", {2'b01, ABORT_BYTE}, e)
  endtask : abort_test

  initial begin
    repeat (8) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    idle_test();
    frame(3, 1'b0, 1'b1);
    frame(4, 1'b1, 1'b1);
    frame(5, 1'b0, 1'b0);
    abort_test();
    stop_test();
  end
endmodule : test_hdlc_frame_terminal_port
`default_nettype wire
